/* inc/event_counter_pkg.sv */
// Constants for the event counter control block
package event_counter_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h0c;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int POL_ONE_BIT = 0;
  localparam int POL_TWO_BIT = 1;
  localparam int CASCADE_BIT = 2;
  localparam int SNAPSHOT_BIT = 3;
  localparam int COUNT_WIDTH = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hffff;
endpackage

/* verilog/event_counter_control.sv */
// Event counter control register, edge detection, counters and snapshot
`timescale 1ns/1ps
`default_nettype none
module event_counter_control
  import event_counter_pkg::*;
#(
  parameter int WIDTH = COUNT_WIDTH
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic event_input_one_in,
  input wire logic event_input_two_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [WIDTH-1:0] snapshot_one_out,
  output logic [WIDTH-1:0] snapshot_two_out
);

  // Synchroniser stages and edge history
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] last_level;
  logic [1:0] next_sync_a;
  logic [1:0] next_sync_b;
  logic [1:0] next_last_level;
  logic [1:0] rise;
  logic [1:0] fall;

  // Control fields
  logic input_one_edge_polarity;
  logic input_two_edge_polarity;
  logic cascade_select;
  logic snapshot_request;
  logic next_pol_one;
  logic next_pol_two;
  logic next_cascade;
  logic next_snapshot;
  logic ctrl_write;

  // Live counts
  logic [WIDTH-1:0] count_one;
  logic [WIDTH-1:0] count_two;
  logic [WIDTH-1:0] next_count_one;
  logic [WIDTH-1:0] next_count_two;
  logic event_one;
  logic event_two;
  logic carry_one;

  // Readback and snapshot
  logic [7:0] next_rdata;
  logic [WIDTH-1:0] next_snap_one;
  logic [WIDTH-1:0] next_snap_two;

  // Pick the edge selected by a polarity bit
  function automatic logic pick_edge(input logic pol, input logic r, input logic f);
    pick_edge = pol ? r : f;
  endfunction

  // Two-stage synchroniser; stage a feeds stage b only
  always_comb begin
    next_sync_a = {event_input_two_in, event_input_one_in};
    next_sync_b = sync_a;
    next_last_level = sync_b;
    rise = sync_b & ~last_level;
    fall = ~sync_b & last_level;
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      last_level <= 2'h0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      last_level <= next_last_level;
    end
  end

  // Control register write; a new request wins over the self-clear
  always_comb begin
    ctrl_write = reg_write_in && (reg_addr_in == CTRL_OFFSET);
    next_pol_one = input_one_edge_polarity;
    next_pol_two = input_two_edge_polarity;
    next_cascade = cascade_select;
    next_snapshot = 1'b0;
    if (ctrl_write) begin
      next_pol_one = reg_wdata_in[POL_ONE_BIT];
      next_pol_two = reg_wdata_in[POL_TWO_BIT];
      next_cascade = reg_wdata_in[CASCADE_BIT];
      next_snapshot = reg_wdata_in[SNAPSHOT_BIT];
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_one_edge_polarity <= CTRL_RESET[POL_ONE_BIT];
      input_two_edge_polarity <= CTRL_RESET[POL_TWO_BIT];
      cascade_select <= CTRL_RESET[CASCADE_BIT];
      snapshot_request <= CTRL_RESET[SNAPSHOT_BIT];
    end else begin
      input_one_edge_polarity <= next_pol_one;
      input_two_edge_polarity <= next_pol_two;
      cascade_select <= next_cascade;
      snapshot_request <= next_snapshot;
    end
  end

  // Counting; polarity is applied to already clean edges, so a change
  // of polarity alone adds no stray count; only an edge of the selected kind counts
  always_comb begin
    event_one = pick_edge(input_one_edge_polarity, rise[0], fall[0]);
    event_two = pick_edge(input_two_edge_polarity, rise[1], fall[1]);
    carry_one = event_one && (count_one == COUNT_FULL[WIDTH-1:0]);
    next_count_one = count_one + WIDTH'(event_one);
    if (cascade_select) begin
      next_count_two = count_two + WIDTH'(carry_one);
    end else begin
      next_count_two = count_two + WIDTH'(event_two);
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_one <= COUNT_RESET[WIDTH-1:0];
      count_two <= COUNT_RESET[WIDTH-1:0];
    end else begin
      count_one <= next_count_one;
      count_two <= next_count_two;
    end
  end

  // Snapshot copies counts while they keep running; readback is registered
  always_comb begin
    next_snap_one = snapshot_one_out;
    next_snap_two = snapshot_two_out;
    if (snapshot_request) begin
      next_snap_one = count_one;
      next_snap_two = count_two;
    end
    next_rdata = 8'h00; // Unmapped offsets and reserved bits read zero
    if (reg_addr_in == CTRL_OFFSET) begin
      next_rdata[POL_ONE_BIT] = input_one_edge_polarity;
      next_rdata[POL_TWO_BIT] = input_two_edge_polarity;
      next_rdata[CASCADE_BIT] = cascade_select;
      next_rdata[SNAPSHOT_BIT] = snapshot_request;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      snapshot_one_out <= COUNT_RESET[WIDTH-1:0];
      snapshot_two_out <= COUNT_RESET[WIDTH-1:0];
      reg_rdata_out <= 8'h00;
    end else begin
      snapshot_one_out <= next_snap_one;
      snapshot_two_out <= next_snap_two;
      reg_rdata_out <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  a_snap_copy_counts:
    assert property (snapshot_request |=> snapshot_one_out == $past(count_one)
                     && snapshot_two_out == $past(count_two))
    else $error("snapshot did not copy live counts");

  a_snap_self_clear:
    assert property (snapshot_request && !ctrl_write |=> !snapshot_request)
    else $error("snapshot request did not clear");

  a_independent_count:
    assert property (!cascade_select && event_two
                     |=> count_two == $past(count_two) + WIDTH'(1'b1))
    else $error("counter two missed own edge");

  a_cascade_carry:
    // Compare at counter width so a wrap of counter two is not seen as a miss
    assert property (cascade_select && carry_one |=> count_one == COUNT_RESET[WIDTH-1:0]
                     && count_two == $past(count_two) + WIDTH'(1'b1))
    else $error("cascade carry lost");

  a_cascade_input_two:
    assert property (cascade_select && !carry_one |=> count_two == $past(count_two))
    else $error("counter two moved without carry in cascade");

  a_wrap_drives_two:
    assert property (cascade_select && event_one && count_one != COUNT_FULL[WIDTH-1:0]
                     |=> count_two == $past(count_two))
    else $error("counter two advanced without wrap");

  a_pol_two_falling:
    assert property (!cascade_select && !input_two_edge_polarity && rise[1]
                     |=> count_two == $past(count_two))
    else $error("input two counted wrong edge");

  a_pol_one_rising:
    assert property (input_one_edge_polarity && rise[0]
                     |=> count_one == $past(count_one) + WIDTH'(1'b1))
    else $error("input one missed rising edge");

  a_pol_one_change:
    assert property ($changed(input_one_edge_polarity) && !rise[0] && !fall[0]
                     |=> count_one == $past(count_one))
    else $error("stray count on polarity change one");

  a_pol_two_change:
    assert property (!cascade_select && $changed(input_two_edge_polarity) && !rise[1] && !fall[1]
                     |=> count_two == $past(count_two))
    else $error("stray count on polarity change two");

  a_edge_single_pulse:
    assert property (rise[0] |=> !rise[0] ##1 !rise[0])
    else $error("edge pulse longer than one cycle");

  c_snapshot_taken: cover property (ctrl_write && reg_wdata_in[SNAPSHOT_BIT] ##1 snapshot_request);
  c_cascade_wrap: cover property (cascade_select && carry_one);
  c_falling_count_two: cover property (!cascade_select && !input_two_edge_polarity && fall[1]);

endmodule
`default_nettype wire

/* dv/event_source.sv */
// Event source model driving the two counter input pins
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input wire logic clk_in,
  output logic pin_one_out,
  output logic pin_two_out
);
  // Pins idle low until a pulse is asked for
  initial begin
    pin_one_out = 1'b0;
    pin_two_out = 1'b0;
  end
  // One full pulse; each level held 3 cycles so no edge is lost
  task automatic pulse(input logic sel_two);
    repeat (3) @(negedge clk_in);
    if (sel_two) pin_two_out = 1'b1;
    else pin_one_out = 1'b1;
    repeat (3) @(negedge clk_in);
    if (sel_two) pin_two_out = 1'b0;
    else pin_one_out = 1'b0;
    // Let the synchroniser latency pass before the caller looks
    repeat (4) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

/* dv/event_counter_control_bench.sv */
// Testbench for the event counter control block
`timescale 1ns/1ps
`default_nettype none
module event_counter_control_bench;
  import event_counter_pkg::*;
  localparam int W = 4; // Short counters so a wrap fits in the run
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h0c;
  logic reg_write_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic [W-1:0] snap_one;
  logic [W-1:0] snap_two;
  wire logic pin_one;
  wire logic pin_two;
  int bad_count = 0;
  int cmp_count = 0;
  int e1 = 0;
  int e2 = 0;
  always #25 core_clk_in = ~core_clk_in;
  event_source src (.clk_in(core_clk_in), .pin_one_out(pin_one), .pin_two_out(pin_two));
  event_counter_control #(.WIDTH(W)) DUT (
    .core_clk_in(core_clk_in), .reset_in(reset_in),
    .event_input_one_in(pin_one), .event_input_two_in(pin_two),
    .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .snapshot_one_out(snap_one), .snapshot_two_out(snap_two));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single-cycle write strobe, driven on the falling edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk_in);
    reg_addr_in = addr;
    reg_wdata_in = data;
    reg_write_in = 1'b1;
    @(negedge core_clk_in);
    reg_write_in = 1'b0;
  endtask
  // Request a snapshot, then compare control and both captured counts
  task automatic snap(input logic [7:0] ctrl);
    wr(CTRL_OFFSET, ctrl | 8'h08);
    repeat (3) @(negedge core_clk_in);
    chk(16'(reg_rdata_out), 16'(ctrl));
    chk(16'(snap_one), 16'(e1 % 16));
    chk(16'(snap_two), 16'(e2 % 16));
  endtask
  task automatic t_reset();
    repeat (2) @(negedge core_clk_in);
    chk(16'(reg_rdata_out), 16'(CTRL_RESET));
    chk(16'({snap_two, snap_one}), 16'h0000);
  endtask
  // Independent counting with the given edge polarities
  task automatic t_indep(input logic [7:0] ctrl);
    wr(CTRL_OFFSET, ctrl);
    src.pulse(1'b0);
    src.pulse(1'b0);
    src.pulse(1'b1);
    e1 += 2;
    e2 += 1;
    snap(ctrl);
  endtask
  // Cascade: pin two and its polarity ignored, wrap of one feeds two
  task automatic t_cascade();
    wr(CTRL_OFFSET, 8'hf6);
    src.pulse(1'b1);
    // Bounded: at most one full wrap of the short counter is needed
    for (int n = 0; n < 16 && e1 % 16 != 0; n++) begin
      src.pulse(1'b0);
      e1++;
    end
    e2++;
    snap(8'h06);
  endtask
  task automatic t_unmapped();
    wr(8'h0d, 8'hff);
    @(negedge core_clk_in);
    chk(16'(reg_rdata_out), 16'h0000);
    reg_addr_in = CTRL_OFFSET;
    repeat (2) @(negedge core_clk_in);
    chk(16'(reg_rdata_out), 16'h0006);
  endtask
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence: reset for 4 cycles, then each scenario
  initial begin
    repeat (4) @(negedge core_clk_in);
    reset_in = 1'b0;
    t_reset();
    t_indep(8'h00);
    t_indep(8'h03);
    t_cascade();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire
